// [src/banked_data_memory_status.sv]
// Banked data memory, pointer indirection and arithmetic status flags of the core.
`timescale 1ns/10ps
`include "bdm_consts.svh"

module banked_data_memory_status (
	// Clock and reset.
	input  wire logic                 clk_i,
	input  wire logic                 sys_rst_i,
	// Requests from the execution unit.
	input  wire bdm_pkg::core_req_t   req_i,
	output logic                      busy_o,
	output bdm_pkg::core_rsp_t        rsp_o,
	// Core events, one-cycle pulses.
	// They come from logic on the same clock, so they need no synchroniser.
	input  wire logic                 wdt_clear_i,
	input  wire logic                 sleep_i,
	input  wire logic                 wdt_timeout_i,
	// Program memory read port.
	// The word must be valid while the read strobe is high.
	output logic                      pm_rd_o,
	output logic [`PM_ADDR_W-1:0]     pm_addr_o,
	input  wire logic [`PM_WORD_W-1:0] pm_data_i,
	// Register views for the rest of the core.
	output logic [7:0]                status_o,
	output logic [7:0]                acc_o,
	output logic [`BANK_W-1:0]        bank_o
);
	import bdm_pkg::*;

	// Stored core registers.
	logic [15:0]         ptr_r [2];
	logic [7:0]          pcl_r;
	logic [7:0]          progctr_high_latch_r;
	logic [7:0]          irq_control_r;
	logic [4:0]          stat_r;
	seq_state_t          state_r;
	core_req_t           held_r;
	loc_t                held_loc_r;

	// General RAM for the first banks and the common RAM of all banks.
	// Only the first banks carry general RAM; the rest read zero and drop writes.
	logic [7:0]          gen_ram_r [`GEN_BANKS*`GEN_SIZE];
	logic [7:0]          com_ram_r [`COM_SIZE];

	// Execute stage signals.
	core_req_t           cur;
	loc_t                loc;
	logic                take;
	logic                start_pm;
	logic                go;
	logic [7:0]          src;
	logic [7:0]          res;
	logic [7:0]          opb;
	logic                cin;
	logic [8:0]          sum;
	logic [4:0]          nib;
	logic [2:0]          aff;
	logic                new_c;
	logic                new_dc;
	logic                wr_en;
	logic [11:0]         wr_addr;
	logic                stat_wr;
	logic [2:0]          flags_nxt;
	logic [2:0]          aff_go;
	logic                flag_wr;

	// True when an address falls in a general RAM bank that is built.
	// Banks above the built ones behave like the peripheral area: zero on read.
	function automatic logic in_gen(input logic [11:0] a);
		in_gen = (a[6:0] >= `OFF_GEN_LO) && (a[6:0] <= `OFF_GEN_HI) &&
			(a[11:7] < 5'(`GEN_BANKS));
	endfunction

	// Flat index into general RAM: bank times window size plus offset.
	function automatic logic [`GEN_IDX_W-1:0] gen_idx(input logic [11:0] a);
		gen_idx = `GEN_IDX_W'(a[11:7]) * `GEN_IDX_W'(`GEN_SIZE) +
			`GEN_IDX_W'(a[6:0] - `OFF_GEN_LO);
	endfunction

	// Maps a request offset to a data or program location.
	// Both indirect ports share one decode; the low offset bit picks the pointer.
	// A pointer that aims back at an indirect port reads zero and writes nothing.
	function automatic loc_t resolve(input logic [6:0] off);
		loc_t l;
		logic [15:0] p;
		p = ptr_r[off[0]];
		l.pm = 1'b0;
		l.pm_addr = p[14:0];
		l.addr = {bank_o, off};
		if (off == `OFF_IND0 || off == `OFF_IND1) begin
			l.addr = p[11:0];
			l.pm = p[`PM_SEL_BIT];
		end
		resolve = l;
	endfunction

	// Read of one data location; only the offset picks core registers.
	// Status reads the stored flags, not the registered view that lags a cycle.
	function automatic logic [7:0] read_loc(input logic [11:0] a);
		logic [7:0] d;
		d = 8'h00;
		case (a[6:0])
			`OFF_PCL:    d = pcl_r;
			`OFF_STATUS: d = {3'h0, stat_r};
			`OFF_PTR0L:  d = ptr_r[0][7:0];
			`OFF_PTR0H:  d = ptr_r[0][15:8];
			`OFF_PTR1L:  d = ptr_r[1][7:0];
			`OFF_PTR1H:  d = ptr_r[1][15:8];
			`OFF_BSR:    d = {3'h0, bank_o};
			`OFF_ACC:    d = acc_o;
			`OFF_PROGCTR_HIGH_LATCH: d = progctr_high_latch_r;
			`OFF_IRQ_CONTROL: d = irq_control_r;
			default: begin
				if (a[6:0] >= `OFF_COM_LO) begin
					d = com_ram_r[a[3:0]];
				end else if (in_gen(a)) begin
					d = gen_ram_r[gen_idx(a)];
				end
			end
		endcase
		read_loc = d;
	endfunction

	// Request selection: a waiting program read finishes with the held request.
	// While the word is fetched the request lines are ignored, so the partner may
	// already move them without disturbing the access in flight.
	always_comb begin
		cur = (state_r == ST_PMWAIT) ? held_r : req_i;
		loc = (state_r == ST_PMWAIT) ? held_loc_r : resolve(req_i.off);
		take = req_i.vld && (state_r == ST_EXEC);
		// Pure writes never read, so they need no program fetch.
		start_pm = take && loc.pm && (req_i.op != OP_WRITE) && (req_i.op != OP_CLR);
		go = (state_r == ST_PMWAIT) || (take && !start_pm);
		// Only the low byte of the program word reaches the datapath.
		src = (state_r == ST_PMWAIT) ? pm_data_i[7:0] : read_loc(loc.addr);
	end

	// Arithmetic and flag computation.
	// Subtraction adds the inverted accumulator plus one, so both carries come out
	// as not-borrow with no extra logic.
	always_comb begin
		opb = (cur.op == OP_SUB) ? ~acc_o : acc_o;
		cin = (cur.op == OP_SUB);
		sum = {1'b0, src} + {1'b0, opb} + {8'h00, cin};
		nib = {1'b0, src[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
		res = src;
		aff = 3'b000;
		new_c = stat_r[`ST_C];
		new_dc = stat_r[`ST_DC];
		case (cur.op)
			OP_WRITE: begin
				res = cur.operand;
			end
			OP_MOVF: begin
				aff = 3'b100;
			end
			OP_CLR: begin
				res = 8'h00;
				aff = 3'b100;
			end
			OP_ADD, OP_SUB: begin
				res = sum[7:0];
				aff = 3'b111;
				new_c = sum[8];
				new_dc = nib[4];
			end
			OP_AND: begin
				res = src & acc_o;
				aff = 3'b100;
			end
			OP_IOR: begin
				res = src | acc_o;
				aff = 3'b100;
			end
			OP_XOR: begin
				res = src ^ acc_o;
				aff = 3'b100;
			end
			OP_RRF: begin
				res = {stat_r[`ST_C], src[7:1]};
				aff = 3'b001;
				new_c = src[0];
			end
			OP_RLF: begin
				res = {src[6:0], stat_r[`ST_C]};
				aff = 3'b001;
				new_c = src[7];
			end
			default: begin
				res = src;
			end
		endcase
	end

	// Destination and status write steering.
	// Flags move only when a request executes: between requests the request lines
	// may still carry an old op, and that must not recompute anything.
	// An op that computes any flag blocks the software write to all three, so the
	// flags that it leaves alone keep their value rather than take the written bits.
	always_comb begin
		wr_addr = cur.dest_acc ? {bank_o, `OFF_ACC} : loc.addr;
		// A file destination in program memory is never written.
		wr_en = go && (cur.op != OP_READ) && !(loc.pm && !cur.dest_acc);
		aff_go = go ? aff : 3'b000;
		stat_wr = wr_en && (wr_addr[6:0] == `OFF_STATUS);
		flag_wr = stat_wr && (aff_go == 3'b000);
		// Flags an op affects take the computed value; plain writes set all three.
		flags_nxt[2] = aff_go[2] ? (res == 8'h00) :
			(flag_wr ? res[`ST_Z] : stat_r[`ST_Z]);
		flags_nxt[1] = aff_go[1] ? new_dc : (flag_wr ? res[`ST_DC] : stat_r[`ST_DC]);
		flags_nxt[0] = aff_go[0] ? new_c : (flag_wr ? res[`ST_C] : stat_r[`ST_C]);
	end

	// Status register: software reaches only the low three flags.
	// The two reset flags are steered apart from the arithmetic ones, so no write
	// to the status register can ever reach them.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stat_r <= `STAT_RST;
		end else begin
			stat_r[2:0] <= flags_nxt;
			// Expiry and powerdown move only on core events, never on writes.
			if (wdt_clear_i) begin
				stat_r[`ST_TO] <= 1'b1;
				stat_r[`ST_PD] <= 1'b1;
			end else if (sleep_i) begin
				stat_r[`ST_TO] <= 1'b1;
				stat_r[`ST_PD] <= 1'b0;
			end
			// A time-out is the last word so a clear in the same cycle cannot hide it.
			if (wdt_timeout_i) begin
				stat_r[`ST_TO] <= 1'b0;
			end
		end
	end

	// Status view follows the stored flags with the unbuilt bits at zero.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status_o <= {3'h0, `STAT_RST};
		end else begin
			status_o <= {3'h0, stat_r};
		end
	end

	// Pointer pairs, one per indirect port.
	// They reset to zero, so both ports first aim at an indirect port and read zero
	// until software loads them.
	for (genvar k = 0; k < 2; k++) begin : g_ptr
		always_ff @(posedge clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				ptr_r[k] <= 16'h0000;
			end else if (wr_en && wr_addr[6:0] == `OFF_PTR0L + 7'(2 * k)) begin
				ptr_r[k][7:0] <= res;
			end else if (wr_en && wr_addr[6:0] == `OFF_PTR0H + 7'(2 * k)) begin
				ptr_r[k][15:8] <= res;
			end
		end
	end

	// Remaining core registers; any bank's copy is the same register.
	// Unbuilt bits of the program counter latch and interrupt control stay zero.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pcl_r <= 8'h00;
			progctr_high_latch_r <= 8'h00;
			irq_control_r <= 8'h00;
			bank_o <= 5'h00;
			acc_o <= 8'h00;
		end else if (wr_en) begin
			case (wr_addr[6:0])
				`OFF_PCL:    pcl_r <= res;
				`OFF_BSR:    bank_o <= res[4:0];
				`OFF_ACC:    acc_o <= res;
				`OFF_PROGCTR_HIGH_LATCH: progctr_high_latch_r <= res & `PROGCTR_HIGH_LATCH_MASK;
				`OFF_IRQ_CONTROL: irq_control_r <= res & `IRQ_CONTROL_MASK;
				default: begin
					acc_o <= acc_o;
				end
			endcase
		end
	end

	// RAM storage carries no reset, as real RAM powers up unknown.
	// A write into an unbuilt bank is dropped, never folded into a built one.
	always_ff @(posedge clk_i) begin
		if (wr_en && wr_addr[6:0] >= `OFF_COM_LO) begin
			com_ram_r[wr_addr[3:0]] <= res;
		end
		if (wr_en && in_gen(wr_addr)) begin
			gen_ram_r[gen_idx(wr_addr)] <= res;
		end
	end

	// Sequencer: a program read holds the request for one extra cycle.
	// The address leaves on a flop and the word comes back within that cycle, so
	// the fetch costs exactly one cycle and no more.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= ST_EXEC;
			busy_o <= 1'b0;
			pm_rd_o <= 1'b0;
			pm_addr_o <= 15'h0000;
		end else begin
			case (state_r)
				ST_EXEC: begin
					if (start_pm) begin
						state_r <= ST_PMWAIT;
						busy_o <= 1'b1;
						pm_rd_o <= 1'b1;
						pm_addr_o <= loc.pm_addr;
					end
				end
				ST_PMWAIT: begin
					state_r <= ST_EXEC;
					busy_o <= 1'b0;
					pm_rd_o <= 1'b0;
				end
				default: begin
					state_r <= ST_EXEC;
					busy_o <= 1'b0;
					pm_rd_o <= 1'b0;
				end
			endcase
		end
	end

	// Held request while the program word is fetched.
	// The resolved location is kept too, so a pointer change cannot move it.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			held_r <= '0;
			held_loc_r <= '0;
		end else if (start_pm) begin
			held_r <= req_i;
			held_loc_r <= loc;
		end
	end

	// Answer: the operation result, one cycle after it executes.
	// Data holds between answers so the partner may pick it up late.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rsp_o <= '0;
		end else begin
			rsp_o.vld <= go;
			rsp_o.data <= go ? res : rsp_o.data;
		end
	end

endmodule

// [src/bdm_consts.svh]
// Offsets, field positions, reset values and sizes for the banked data memory block.
`ifndef BDM_CONSTS_SVH
`define BDM_CONSTS_SVH

// Core register offsets, repeated at the head of every bank.
`define OFF_IND0    7'h00
`define OFF_IND1    7'h01
`define OFF_PCL     7'h02
`define OFF_STATUS  7'h03
`define OFF_PTR0L   7'h04
`define OFF_PTR0H   7'h05
`define OFF_PTR1L   7'h06
`define OFF_PTR1H   7'h07
`define OFF_BSR     7'h08
`define OFF_ACC     7'h09
`define OFF_PROGCTR_HIGH_LATCH  7'h0a
`define OFF_IRQ_CONTROL  7'h0b
`define OFF_CORE_HI 7'h0b

// RAM windows inside a bank.
`define OFF_GEN_LO  7'h20
`define OFF_GEN_HI  7'h6f
`define OFF_COM_LO  7'h70
`define GEN_SIZE    80
`define COM_SIZE    16
`define GEN_BANKS   4
`define GEN_IDX_W   9

// Address layout.
`define BANK_W      5
`define OFF_W       7
`define ADDR_W      12
`define PM_ADDR_W   15
`define PM_WORD_W   14
`define PM_SEL_BIT  15

// Implemented bit masks.
`define BSR_MASK    8'h1f
`define PROGCTR_HIGH_LATCH_MASK 8'h7f
`define IRQ_CONTROL_MASK 8'hc1

// Status bit positions and reset value.
`define ST_TO       4
`define ST_PD       3
`define ST_Z        2
`define ST_DC       1
`define ST_C        0
`define STAT_RST    5'h18

`endif

// [src/bdm_pkg.sv]
// Types shared between the banked data memory block and its execution unit.
package bdm_pkg;

	// Operation requested by the execution unit.
	typedef enum logic [3:0] {
		OP_READ  = 4'h0,
		OP_WRITE = 4'h1,
		OP_MOVF  = 4'h2,
		OP_CLR   = 4'h3,
		OP_ADD   = 4'h4,
		OP_SUB   = 4'h5,
		OP_AND   = 4'h6,
		OP_IOR   = 4'h7,
		OP_XOR   = 4'h8,
		OP_RRF   = 4'h9,
		OP_RLF   = 4'ha
	} op_t;

	// One request, taken in a single cycle.
	typedef struct packed {
		logic       vld;
		op_t        op;
		logic       dest_acc;
		logic [6:0] off;
		logic [7:0] operand;
	} core_req_t;

	// Answer to a request.
	typedef struct packed {
		logic       vld;
		logic [7:0] data;
	} core_rsp_t;

	// Resolved location of a request.
	typedef struct packed {
		logic        pm;
		logic [14:0] pm_addr;
		logic [11:0] addr;
	} loc_t;

	// Sequencer states.
	typedef enum logic [1:0] {
		ST_EXEC   = 2'b01,
		ST_PMWAIT = 2'b10
	} seq_state_t;

endpackage

// [test/bdm_asserts.sv]
// Port-level assertions for the banked data memory block.
`timescale 1ns/10ps
module bdm_asserts import bdm_pkg::*; (
	// Clock, reset and requests.
	input wire logic	clk_i,
	input wire logic	sys_rst_i,
	input wire core_req_t	req_i,
	input wire logic	busy_o,
	input wire core_rsp_t	rsp_o,
	// Core events.
	input wire logic	wdt_clear_i,
	input wire logic	sleep_i,
	input wire logic	wdt_timeout_i,
	// Program port and register views.
	input wire logic	pm_rd_o,
	input wire logic [13:0]	pm_data_i,
	input wire logic [7:0]	status_o,
	input wire logic [4:0]	bank_o
);
	// One clock domain, so clock and reset are given once.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_pm_busy; pm_rd_o |-> busy_o; endproperty
	a_pm_busy: assert property (p_pm_busy) else $error("not busy on program read");
	property p_pm_rsp; pm_rd_o |=> rsp_o.vld && !busy_o; endproperty
	a_pm_rsp: assert property (p_pm_rsp) else $error("late program answer");
	property p_busy1; busy_o |=> !busy_o; endproperty
	a_busy1: assert property (p_busy1) else $error("busy too long");
	property p_pm_data;
		pm_rd_o && $past(req_i.op) == OP_READ |=> rsp_o.data == $past(pm_data_i[7:0]);
	endproperty
	a_pm_data: assert property (p_pm_data) else $error("bad program byte");
	property p_st_hi; status_o[7:5] == 3'h0; endproperty
	a_st_hi: assert property (p_st_hi) else $error("status top bits set");
	property p_tout; wdt_timeout_i |-> ##2 !status_o[4]; endproperty
	a_tout: assert property (p_tout) else $error("expiry flag not cleared");
	property p_sleep;
		sleep_i && !wdt_clear_i && !wdt_timeout_i |-> ##2 status_o[4:3] == 2'b10;
	endproperty
	a_sleep: assert property (p_sleep) else $error("bad flags after sleep");
	property p_wclr;
		wdt_clear_i && !sleep_i && !wdt_timeout_i |-> ##2 status_o[4:3] == 2'b11;
	endproperty
	a_wclr: assert property (p_wclr) else $error("bad flags after clear");
	// Software never moves the reset flags; only an event two edges back may.
	property p_ro;
		$changed(status_o[4:3]) |-> $past(wdt_clear_i || sleep_i || wdt_timeout_i, 2);
	endproperty
	a_ro: assert property (p_ro) else $error("reset flags moved");
	property p_bank; $changed(bank_o) |-> rsp_o.vld; endproperty
	a_bank: assert property (p_bank) else $error("bank moved unasked");
	c_pm: cover property (pm_rd_o);
	c_sleep: cover property (sleep_i);
	c_tout: cover property (wdt_timeout_i);
endmodule

// [test/pm_model.sv]
// Program memory model answering the block's read port.
`timescale 1ns/10ps
module pm_model (
	// Clock and read request.
	input wire logic	clk_i,
	input wire logic	rd_i,
	input wire logic [14:0]	addr_i,
	// Program word.
	output logic [13:0]	data_o
);
	logic	tog_r = 1'b0;
	// The idle pattern flips every cycle so a stale word never passes for a real one.
	always @(posedge clk_i) tog_r <= ~tog_r;
	// Words are read only; the model has no write path.
	assign data_o = rd_i ? addr_i[13:0] ^ {addr_i[6:0], addr_i[14:8]} : {7{tog_r, ~tog_r}};
endmodule

// [test/tb_top.sv]
// Self-checking bench for the banked data memory and status block.
`timescale 1ns/10ps
`include "bdm_consts.svh"
module tb_top;
	import bdm_pkg::*;
	// Design ports and bench state.
	logic	clk_i = 1'b0;
	logic	sys_rst_i = 1'b1;
	core_req_t	req_i = '0;
	core_rsp_t	rsp_o;
	logic	busy_o, pm_rd_o;
	logic	wdt_clear_i = 1'b0, sleep_i = 1'b0, wdt_timeout_i = 1'b0;
	logic [14:0]	pm_addr_o;
	logic [13:0]	pm_data_i;
	logic [7:0]	status_o, acc_o, d, a, b, e;
	op_t	lop;
	logic [4:0]	bank_o;
	logic [2:0]	fl;
	logic [7:0]	cf [4] = '{8'h00, 8'h0f, 8'hff, 8'h80};
	logic [7:0]	cw [4] = '{8'h00, 8'h01, 8'h01, 8'h80};
	int	mismatches = 0, checked = 0, cyc = 0, seed = 36, lat, lat0;

	// Free-running 50 MHz clock.
	always #10 clk_i = ~clk_i;

	banked_data_memory_status banked_data_memory_status_inst (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .req_i(req_i), .busy_o(busy_o), .rsp_o(rsp_o),
		.wdt_clear_i(wdt_clear_i), .sleep_i(sleep_i), .wdt_timeout_i(wdt_timeout_i),
		.pm_rd_o(pm_rd_o), .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i),
		.status_o(status_o), .acc_o(acc_o), .bank_o(bank_o));
	pm_model pm_model_inst (.clk_i(clk_i), .rd_i(pm_rd_o), .addr_i(pm_addr_o),
		.data_o(pm_data_i));

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// A hang ends the run as a failure.
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			mismatches++;
			conclude();
		end
	end
	// Expected {zero, digit carry, carry}; subtraction adds the inverted acc plus one.
	function automatic logic [2:0] af(input logic [7:0] f, input logic [7:0] w, input logic s);
		logic [8:0] r;
		logic [4:0] h;
		r = {1'b0, f} + {1'b0, s ? ~w : w} + 9'(s);
		h = {1'b0, f[3:0]} + {1'b0, s ? ~w[3:0] : w[3:0]} + 5'(s);
		return {r[7:0] == 8'h00, h[4], r[8]};
	endfunction
	// Low byte of the word that the program memory model returns.
	function automatic logic [7:0] pw(input logic [14:0] x);
		return x[7:0] ^ {x[0], x[14:8]};
	endfunction
	// One request, held through its taking edge; lat counts cycles to the answer.
	task automatic xf(input op_t o, input logic da, input logic [6:0] f, input logic [7:0] v);
		req_i = '{1'b1, o, da, f, v};
		@(posedge clk_i);
		#1 req_i.vld = 1'b0;
		lat = 0;
		while (rsp_o.vld !== 1'b1 && lat < 5) begin
			@(posedge clk_i);
			#1 lat++;
		end
		d = rsp_o.data;
		if (lat == 5)
			chk(8'h00, 8'hff);
		@(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [6:0] f, input logic [7:0] v);
		xf(OP_WRITE, 1'b0, f, v);
	endtask
	task automatic rd(input logic [6:0] f);
		xf(OP_READ, 1'b0, f, 8'h00);
	endtask
	// Pulse one core event (0 timeout, 1 sleep, 2 clear) and check the reset flags.
	task automatic ev(input int k, input logic [1:0] e);
		{wdt_clear_i, sleep_i, wdt_timeout_i} = 3'b001 << k;
		@(posedge clk_i);
		#1 {wdt_clear_i, sleep_i, wdt_timeout_i} = 3'b000;
		repeat (2) @(posedge clk_i);
		#1 chk(status_o & 8'hf8, {3'h0, e, 3'h0});
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		#1 sys_rst_i = 1'b0;
		chk(status_o, 8'h18);
		// Bank selection, mirrored core registers, shared and missing locations.
		for (int i = 0; i < 4; i++) begin
			b = (i == 0) ? 8'hff : 8'($random(seed)) & 8'h1f;
			a = 8'($random(seed));
			wr(`OFF_BSR, b);
			chk(8'(bank_o), b & 8'h1f);
			rd(`OFF_BSR);
			chk(d, b & 8'h1f);
			wr(7'h70 + 7'(i), a);
			wr(`OFF_BSR, b ^ 8'h0f);
			rd(7'h70 + 7'(i));
			chk(d, a);
			rd(7'h0c);
			chk(d, 8'h00);
		end
		// General RAM by bank and through both pointers.
		wr(`OFF_BSR, 8'h02);
		wr(7'h30, a);
		wr(`OFF_BSR, 8'h09);
		rd(7'h30);
		chk(d, 8'h00);
		wr(`OFF_PTR0H, 8'h01);
		wr(`OFF_PTR0L, 8'h30);
		rd(`OFF_IND0);
		chk(d, a);
		wr(`OFF_IND0, ~a);
		wr(`OFF_PTR1H, 8'h01);
		wr(`OFF_PTR1L, 8'h30);
		rd(`OFF_IND1);
		chk(d, ~a);
		// Program memory through pointer one.
		for (int i = 0; i < 4; i++) begin
			a = 8'($random(seed)) | 8'h70;
			b = 8'($random(seed)) & 8'h7f;
			wr(`OFF_PTR1H, b | 8'h80);
			wr(`OFF_PTR1L, a);
			// The common RAM byte that shares the pointer's low bits must survive.
			wr(a[6:0], 8'ha5);
			lat0 = lat;
			xf(OP_MOVF, 1'b1, `OFF_IND1, 8'h00);
			chk(acc_o, pw({b[6:0], a}));
			chk(8'(lat - lat0), 8'h01);
			wr(`OFF_IND1, 8'h5a);
			rd(`OFF_IND1);
			chk(d, pw({b[6:0], a}));
			rd(a[6:0]);
			chk(d, 8'ha5);
		end
		// Add and subtract with corner values first, then rotates through carry.
		for (int i = 0; i < 12; i++) begin
			a = (i < 4) ? cf[i] : 8'($random(seed));
			b = (i < 4) ? cw[i] : 8'($random(seed));
			wr(`OFF_ACC, b);
			wr(7'h71, a);
			xf(i[0] ? OP_SUB : OP_ADD, 1'b1, 7'h71, 8'h00);
			fl = af(a, b, i[0]);
			chk(d, a + (i[0] ? ~b : b) + 8'(i[0]));
			rd(`OFF_STATUS);
			chk(d & 8'h07, 8'(fl));
			xf(i[0] ? OP_RLF : OP_RRF, 1'b1, 7'h71, 8'h00);
			chk(d, i[0] ? {a[6:0], fl[0]} : {fl[0], a[7:1]});
			rd(`OFF_STATUS);
			chk(8'(d[0]), 8'(i[0] ? a[7] : a[0]));
		end
		// Logic ops move only the zero flag; the first pass forces zero results from AND and XOR, not IOR.
		for (int i = 0; i < 6; i++) begin
			a = (i < 3) ? 8'h0f : 8'($random(seed));
			b = (i < 3) ? ((i == 2) ? 8'h0f : 8'hf0) : 8'($random(seed));
			lop = op_t'(4'h6 + 4'(i % 3));
			e = (i % 3 == 0) ? (a & b) : (i % 3 == 1) ? (a | b) : (a ^ b);
			wr(`OFF_STATUS, 8'h03);
			wr(`OFF_ACC, b);
			wr(7'h72, a);
			xf(lop, 1'b1, 7'h72, 8'h00);
			chk(d, e);
			rd(`OFF_STATUS);
			chk(d & 8'h07, {5'h00, e == 8'h00, 2'b11});
		end
		// Sleep event, status as destination, then the timeout and clear events.
		ev(1, 2'b10);
		wr(`OFF_STATUS, 8'hf3);
		rd(`OFF_STATUS);
		chk(d, 8'h13);
		xf(OP_CLR, 1'b0, `OFF_STATUS, 8'h00);
		rd(`OFF_STATUS);
		chk(d, 8'h17);
		wr(`OFF_STATUS, 8'h00);
		wr(`OFF_ACC, 8'hf0);
		xf(OP_ADD, 1'b0, `OFF_STATUS, 8'h00);
		rd(`OFF_STATUS);
		chk(d, 8'h15);
		ev(0, 2'b00);
		ev(2, 2'b11);
		wr(`OFF_STATUS, 8'h00);
		rd(`OFF_STATUS);
		chk(d, 8'h18);
		conclude();
	end
endmodule

bind banked_data_memory_status bdm_asserts bdm_asserts_inst (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .req_i(req_i), .busy_o(busy_o), .rsp_o(rsp_o),
	.wdt_clear_i(wdt_clear_i), .sleep_i(sleep_i), .wdt_timeout_i(wdt_timeout_i),
	.pm_rd_o(pm_rd_o), .pm_data_i(pm_data_i), .status_o(status_o), .bank_o(bank_o));
